// ### hw/dpf_pin_function.sv
// Pin function configuration: three subregisters, role muxing and alternate functions
`timescale 1ns/1ps
module dpf_pin_function (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire dpf_pkg::dpf_cfg_req_t  cfg_req,         // Register access request
  output logic [15:0]                 cfg_rdata,       // Read data
  output logic                        cfg_rvalid,      // Read data valid, one cycle
  input  wire logic [11:0]            pin_in,          // Raw pad levels
  output logic [11:0]                 pin_out,         // Pad output values
  output logic [11:0]                 pin_oe,          // Pad output enables
  input  wire logic [11:0]            gpio_data,       // GPIO data register bits
  output logic [11:0]                 gpio_level,      // Synchronised pad levels
  input  wire logic                   adc_busy,        // Conversion in progress
  input  wire logic                   limit_a_raw,     // Limit event A, active high
  input  wire logic                   limit_b_raw,     // Limit event B, active high
  output logic                        dac_load_strobe, // Load strobe from pin 3
  output logic                        dac_off_input_a, // DAC-off request from pin 2
  output logic                        dac_off_input_b, // DAC-off request from pin 4
  output dpf_pkg::dpf_pulldown_t      dac_off_pd,      // Pull-down selects
  output logic                        ext_ref_sel      // 1 = external reference
);

  logic [15:0] drv_q;      // Driver enable subregister
  logic [15:0] role_q;     // Role select subregister
  logic [15:0] gen_q;      // General settings subregister
  logic [11:0] alt_out;    // Alternate output values per pin
  logic [11:0] alt_in;     // Alternate input levels per pin
  logic [1:0]  mode;       // DAC-off pull-down mode field
  logic        wr_drv;     // Write strobe to driver subregister
  logic        wr_role;    // Write strobe to role subregister
  logic        wr_gen;     // Write strobe to general subregister
  logic        lim_a_pin;  // Limit flag A after polarity
  logic        lim_b_pin;  // Limit flag B after polarity
  dpf_pkg::dpf_pulldown_t pd_d;  // Next pull-down selects

  // Subaddress decode
  assign wr_drv  = cfg_req.wr && (cfg_req.sub == dpf_pkg::SUB_DRIVER_EN);
  assign wr_role = cfg_req.wr && (cfg_req.sub == dpf_pkg::SUB_ROLE_SEL);
  assign wr_gen  = cfg_req.wr && (cfg_req.sub == dpf_pkg::SUB_GENERAL);

  // Driver enable subregister; all 16 bits stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_q <= dpf_pkg::DRIVER_EN_RESET;
    end else if (wr_drv) begin
      drv_q <= cfg_req.wdata;
    end
  end

  // Role select subregister; reset puts dual pins in alternate role
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      role_q <= dpf_pkg::ROLE_SEL_RESET;
    end else if (wr_role) begin
      role_q <= cfg_req.wdata;
    end
  end

  // General settings subregister
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_q <= dpf_pkg::GENERAL_RESET;
    end else if (wr_gen) begin
      gen_q <= cfg_req.wdata;
    end
  end

  // Read port: one cycle after the strobe, unmapped reads return zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata  <= 16'h0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      if (cfg_req.rd) begin
        case (cfg_req.sub)
          dpf_pkg::SUB_DRIVER_EN: cfg_rdata <= drv_q;
          dpf_pkg::SUB_ROLE_SEL:  cfg_rdata <= role_q;
          dpf_pkg::SUB_GENERAL:   cfg_rdata <= gen_q;
          default:                cfg_rdata <= dpf_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end

  // Limit flag polarity: 0 gives active low, 1 active high
  assign lim_a_pin = gen_q[dpf_pkg::GEN_POL_A] ? limit_a_raw : !limit_a_raw;
  assign lim_b_pin = gen_q[dpf_pkg::GEN_POL_B] ? limit_b_raw : !limit_b_raw;

  // Alternate output sources for the three output-capable dual pins
  always_comb begin
    alt_out                       = 12'h000;
    alt_out[dpf_pkg::PIN_LIMIT_A] = lim_a_pin;
    alt_out[dpf_pkg::PIN_LIMIT_B] = lim_b_pin;
    alt_out[dpf_pkg::PIN_BUSY]    = adc_busy;
  end

  // One cell per pin; role bits of single-function pins are expected set
  for (genvar i = 0; i < dpf_pkg::PIN_COUNT; i++) begin : g_pin
    dpf_pin_cell #(
      .ALT_OUT(i == dpf_pkg::PIN_LIMIT_A || i == dpf_pkg::PIN_LIMIT_B ||
               i == dpf_pkg::PIN_BUSY),
      .ALT_IN (i == dpf_pkg::PIN_DAC_OFFA || i == dpf_pkg::PIN_LOAD ||
               i == dpf_pkg::PIN_DAC_OFFB)
    ) u_cell (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (pin_in[i]),
      .role_gpio(role_q[i]),
      .drv_en   (drv_q[i]),
      .gpio_val (gpio_data[i]),
      .alt_val  (alt_out[i]),
      .pin_out  (pin_out[i]),
      .pin_oe   (pin_oe[i]),
      .pin_level(gpio_level[i]),
      .alt_in   (alt_in[i])
    );
  end

  // Alternate inputs, held low while their pin is in GPIO role
  assign dac_off_input_a = alt_in[dpf_pkg::PIN_DAC_OFFA];
  assign dac_load_strobe = alt_in[dpf_pkg::PIN_LOAD];
  assign dac_off_input_b = alt_in[dpf_pkg::PIN_DAC_OFFB];

  // Reference select straight from the stored bit
  assign ext_ref_sel = gen_q[dpf_pkg::GEN_EXT_REF];

  assign mode = gen_q[dpf_pkg::GEN_MODE_LSB +: 2];

  // Pull-down decode, applied only to pins in DAC-off role
  always_comb begin
    pd_d = '0;
    if (!role_q[dpf_pkg::PIN_DAC_OFFA]) begin
      pd_d.pd_small_a = (mode != dpf_pkg::MODE_LARGE);
      pd_d.pd_large_a = (mode == dpf_pkg::MODE_BOTH) || (mode == dpf_pkg::MODE_LARGE);
    end
    if (!role_q[dpf_pkg::PIN_DAC_OFFB]) begin
      pd_d.pd_small_b = (mode != dpf_pkg::MODE_LARGE);
      pd_d.pd_large_b = (mode == dpf_pkg::MODE_BOTH) || (mode == dpf_pkg::MODE_LARGE);
    end
  end

  // Registered pull-down selects
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_off_pd <= '0;
    end else begin
      dac_off_pd <= pd_d;
    end
  end

  // Checks on the pin muxing and register behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_busy_pin;
    !role_q[6] |=> pin_out[6] == $past(adc_busy);
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy not on pin 6");

  property p_off_b_quiet;
    role_q[4] |-> !dac_off_input_b;
  endproperty
  a_off_b_quiet: assert property (p_off_b_quiet) else $error("dac off B active in GPIO role");

  // A strobe input must never be driven while it listens to the pad
  property p_load_no_drive;
    !role_q[3] |=> !pin_oe[3];
  endproperty
  a_load_no_drive: assert property (p_load_no_drive) else $error("load pin driven");

  property p_flag_b_high;
    !role_q[1] && gen_q[5] |=> pin_out[1] == $past(limit_b_raw);
  endproperty
  a_flag_b_high: assert property (p_flag_b_high) else $error("flag B polarity wrong");

  property p_flag_a_low;
    !role_q[0] && !gen_q[4] |=> pin_out[0] == !$past(limit_a_raw);
  endproperty
  a_flag_a_low: assert property (p_flag_a_low) else $error("flag A polarity wrong");

  property p_gpio_drive;
    role_q[0] && drv_q[0] |=> pin_oe[0] && pin_out[0] == $past(gpio_data[0]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("GPIO data not on pin 0");

  property p_driver_off;
    !drv_q[11] |=> !pin_oe[11];
  endproperty
  a_driver_off: assert property (p_driver_off) else $error("pin 11 driven while disabled");

  property p_ref_write;
    wr_gen && cfg_req.wdata[8] |=> ext_ref_sel;
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("external reference not selected");

  property p_large_only;
    !role_q[2] && mode == 2'h1 |=> dac_off_pd.pd_large_a && !dac_off_pd.pd_small_a;
  endproperty
  a_large_only: assert property (p_large_only) else $error("pull-down mode 1 wrong");

  property p_pd_gated;
    role_q[4] |=> !dac_off_pd.pd_large_b && !dac_off_pd.pd_small_b;
  endproperty
  a_pd_gated: assert property (p_pd_gated) else $error("pull-down active in GPIO role");

  property p_readback;
    wr_role ##1 cfg_req.rd && cfg_req.sub == 8'h02 && !cfg_req.wr
      |=> cfg_rvalid && cfg_rdata == $past(cfg_req.wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("role readback mismatch");

  c_busy_mode: cover property (!role_q[6] && adc_busy ##1 pin_out[6]);
  c_load_seen: cover property ($rose(dac_load_strobe));
  c_ext_ref:   cover property ($rose(ext_ref_sel));
  c_mode_large: cover property (dac_off_pd.pd_large_b && !dac_off_pd.pd_small_b);

endmodule

// ### hw/dpf_pkg.sv
// Package: register map, field positions, reset values and carriers for the pin function block
package dpf_pkg;

  // Number of digital I/O pins
  localparam int unsigned PIN_COUNT = 12;

  // Configuration bank subaddresses
  localparam logic [7:0] SUB_DRIVER_EN = 8'h01;  // Per-pin output driver enables
  localparam logic [7:0] SUB_ROLE_SEL  = 8'h02;  // Per-pin GPIO / alternate role
  localparam logic [7:0] SUB_GENERAL   = 8'h08;  // Reference, polarity, pull-down mode

  // Reset values: the whole configuration bank powers up cleared
  localparam logic [15:0] DRIVER_EN_RESET = 16'h0000;
  localparam logic [15:0] ROLE_SEL_RESET  = 16'h0000;
  localparam logic [15:0] GENERAL_RESET   = 16'h0000;

  // Pin indices of the dual-use pins
  localparam int unsigned PIN_LIMIT_A  = 0;  // Limit flag output A
  localparam int unsigned PIN_LIMIT_B  = 1;  // Limit flag output B
  localparam int unsigned PIN_DAC_OFFA = 2;  // DAC-off input A
  localparam int unsigned PIN_LOAD     = 3;  // DAC load strobe input
  localparam int unsigned PIN_DAC_OFFB = 4;  // DAC-off input B
  localparam int unsigned PIN_BUSY     = 6;  // Conversion busy output

  // Field positions in the general settings register
  localparam int unsigned GEN_MODE_LSB = 1;  // DAC-off pull-down mode, two bits
  localparam int unsigned GEN_POL_A    = 4;  // Limit flag A polarity
  localparam int unsigned GEN_POL_B    = 5;  // Limit flag B polarity
  localparam int unsigned GEN_EXT_REF  = 8;  // External reference select

  // DAC-off pull-down mode encodings
  localparam logic [1:0] MODE_BOTH  = 2'h0;  // Both resistors in parallel
  localparam logic [1:0] MODE_LARGE = 2'h1;  // Large resistor only
  // Codes 2 and 3 both give the small resistor only

  // Read answer for an unmapped subaddress
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // Register access request from the serial front end
  typedef struct packed {
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [7:0]  sub;    // Subaddress within the configuration bank
    logic [15:0] wdata;  // Write data
  } dpf_cfg_req_t;

  // Pull-down controls for the two DAC-off pins
  typedef struct packed {
    logic pd_small_a;  // Small resistor on input A
    logic pd_large_a;  // Large resistor on input A
    logic pd_small_b;  // Small resistor on input B
    logic pd_large_b;  // Large resistor on input B
  } dpf_pulldown_t;

endpackage

// ### hw/dpf_pin_cell.sv
// One digital I/O pin: input synchroniser, role mux and output driver control
`timescale 1ns/1ps
module dpf_pin_cell #(
  parameter bit ALT_OUT = 1'b0,  // Alternate role drives the pin
  parameter bit ALT_IN  = 1'b0   // Alternate role reads the pin
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,     // Raw pad level, asynchronous
  input  wire logic role_gpio,  // 1 = GPIO role, 0 = alternate role
  input  wire logic drv_en,     // Output driver enable bit
  input  wire logic gpio_val,   // GPIO data bit
  input  wire logic alt_val,    // Alternate function output value
  output logic      pin_out,    // Registered pad output value
  output logic      pin_oe,     // Registered pad output enable
  output logic      pin_level,  // Synchronised pad level
  output logic      alt_in      // Synchronised level for the alternate input
);

  logic meta_q;  // First synchroniser stage, read only by sync_q
  logic sync_q;  // Second synchroniser stage
  logic alt_sel; // Alternate role active

  assign alt_sel = !role_gpio;

  // Two-flop synchroniser for the pad level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // Output value: alternate source or GPIO data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
    end else if (ALT_OUT && alt_sel) begin
      pin_out <= alt_val;
    end else begin
      pin_out <= gpio_val;
    end
  end

  // Driver follows its enable bit, but an alternate input never drives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= drv_en && !(ALT_IN && alt_sel);
    end
  end

  assign pin_level = sync_q;
  // Alternate input is held low while the pin is in its GPIO role
  assign alt_in    = ALT_IN && alt_sel && sync_q;

endmodule

// ### tb/dpf_host_model.sv
// Host model: issues configuration bank accesses on the strobe interface
`timescale 1ns/1ps
module dpf_host_model (
  input  wire logic             core_clk,
  output dpf_pkg::dpf_cfg_req_t cfg_req,
  input  wire logic [15:0]      cfg_rdata,
  input  wire logic             cfg_rvalid
);
  // Idle bus: no strobe, address and data lines carry junk
  initial cfg_req = '{wr: 1'b0, rd: 1'b0, sub: 8'hA5, wdata: 16'h5A5A};

  // Legal write value: reserved positions cleared, single-function roles set to GPIO
  function automatic logic [15:0] legal(input logic [7:0] sub, input logic [15:0] d);
    case (sub)
      dpf_pkg::SUB_ROLE_SEL: return (d | 16'h0FA0) & 16'h0FFF;
      dpf_pkg::SUB_GENERAL:  return d & 16'h0136;
      default:               return d & 16'h0FFF;
    endcase
  endfunction

  // One request, held over its taking edge; lines stay until the next request or idle
  // so back-to-back calls never assign the bus twice in one time step
  task automatic req(input logic w, input logic [7:0] sub, input logic [15:0] d);
    cfg_req = '{wr: w, rd: !w, sub: sub, wdata: w ? legal(sub, d) : ~d};
    @(posedge core_clk);
    #1;
  endtask

  // Release the strobes; address and data lines carry junk while idle
  task automatic idle();
    cfg_req = '{wr: 1'b0, rd: 1'b0, sub: ~cfg_req.sub, wdata: ~cfg_req.wdata};
  endtask

  // Read: valid and data stand in the cycle right after the taking edge
  task automatic rd_reg(input logic [7:0] sub, output logic [15:0] d, output logic ok);
    req(1'b0, sub, 16'h0000);
    ok = cfg_rvalid;
    d  = cfg_rdata;
  endtask
endmodule

// ### tb/dpf_pin_function_tb_top.sv
// Testbench: register access, role muxing and pad behaviour of the pin function block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module dpf_pin_function_tb_top;
  logic                  core_clk, rst_n;
  dpf_pkg::dpf_cfg_req_t cfg_req;
  logic [15:0]           cfg_rdata, rd;
  logic                  cfg_rvalid, ok;
  logic [11:0]           pin_in, pin_out, pin_oe, gpio_data, gpio_level;
  logic                  adc_busy, limit_a_raw, limit_b_raw;
  logic                  dac_load_strobe, dac_off_input_a, dac_off_input_b, ext_ref_sel;
  dpf_pkg::dpf_pulldown_t dac_off_pd;
  int                    n_errors, n_compared, cycles;
  // Expected pull-down selects per mode code
  localparam logic [3:0] PD_EXP [4] = '{4'hF, 4'h5, 4'hA, 4'hA};

  dpf_pin_function i_dpf_pin_function (
    .core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .gpio_data(gpio_data), .gpio_level(gpio_level), .adc_busy(adc_busy),
    .limit_a_raw(limit_a_raw), .limit_b_raw(limit_b_raw),
    .dac_load_strobe(dac_load_strobe), .dac_off_input_a(dac_off_input_a),
    .dac_off_input_b(dac_off_input_b), .dac_off_pd(dac_off_pd), .ext_ref_sel(ext_ref_sel)
  );

  dpf_host_model i_dpf_host_model (
    .core_clk(core_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid)
  );

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Register write through the host model
  task automatic wr(input logic [7:0] sub, input logic [15:0] d);
    i_dpf_host_model.req(1'b1, sub, d);
  endtask

  // Register read with valid strobe and value compared
  task automatic chk_reg(input string nm, input logic [7:0] sub, input logic [15:0] e);
    i_dpf_host_model.rd_reg(sub, rd, ok);
    `CHK("cfg_rvalid", 1'b1, ok)
    `CHK(nm, e, rd)
  endtask

  // Release the bus, then let registered outputs and the two-flop input path catch up
  task automatic settle();
    i_dpf_host_model.idle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // Counts, verdict and end of run
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      $display("unexpected cycle_limit expected %0d seen %0d", 0, cycles);
      test_done();
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0; pin_in = 12'h000; gpio_data = 12'h000; adc_busy = 1'b0;
    limit_a_raw = 1'b0; limit_b_raw = 1'b0; n_errors = 0; n_compared = 0; cycles = 0;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    // Reset state of outputs and subregisters
    `CHK("pin_oe", 12'h000, pin_oe)
    `CHK("ext_ref_sel", 1'b0, ext_ref_sel)
    chk_reg("driver_en", dpf_pkg::SUB_DRIVER_EN, dpf_pkg::DRIVER_EN_RESET);
    // Pull-down selects are registered: mode 00 shows from the first edge after release
    `CHK("dac_off_pd", 4'hF, dac_off_pd)
    chk_reg("role_sel", dpf_pkg::SUB_ROLE_SEL, dpf_pkg::ROLE_SEL_RESET);
    chk_reg("general", dpf_pkg::SUB_GENERAL, dpf_pkg::GENERAL_RESET);
    chk_reg("unmapped", 8'h10, dpf_pkg::UNMAPPED_READ);
    $display("test reset finished");
    // Alternate roles with all drivers enabled
    wr(dpf_pkg::SUB_DRIVER_EN, 16'h0FFF);
    wr(dpf_pkg::SUB_ROLE_SEL, 16'h0000);
    chk_reg("role_sel", dpf_pkg::SUB_ROLE_SEL, 16'h0FA0);
    chk_reg("driver_en", dpf_pkg::SUB_DRIVER_EN, 16'h0FFF);
    adc_busy = 1'b1; limit_a_raw = 1'b1; pin_in = 12'h01C;
    settle();
    `CHK("busy_pin", 2'h3, {pin_out[6], pin_oe[6]})
    `CHK("flag_a_pin", 1'b0, pin_out[0])
    `CHK("flag_b_pin", 1'b1, pin_out[1])
    `CHK("alt_input_oe", 12'h000, pin_oe & 12'h01C)
    `CHK("dac_load_strobe", 1'b1, dac_load_strobe)
    `CHK("dac_off_input_a", 1'b1, dac_off_input_a)
    `CHK("dac_off_input_b", 1'b1, dac_off_input_b)
    wr(dpf_pkg::SUB_GENERAL, 16'h0030);
    settle();
    `CHK("flag_a_pin", 1'b1, pin_out[0])
    `CHK("flag_b_pin", 1'b0, pin_out[1])
    chk_reg("general", dpf_pkg::SUB_GENERAL, 16'h0030);
    $display("test alternate roles finished");
    // Every pull-down mode code
    for (int m = 0; m < 4; m++) begin
      wr(dpf_pkg::SUB_GENERAL, 16'(m << dpf_pkg::GEN_MODE_LSB));
      settle();
      `CHK("dac_off_pd", PD_EXP[m], dac_off_pd)
    end
    $display("test pull-down modes finished");
    // GPIO roles, external reference, then drivers off
    gpio_data = 12'hA5C;
    wr(dpf_pkg::SUB_GENERAL, 16'h0100);
    wr(dpf_pkg::SUB_ROLE_SEL, 16'h0FFF);
    settle();
    `CHK("pin_out", 12'hA5C, pin_out)
    `CHK("pin_oe", 12'hFFF, pin_oe)
    `CHK("gpio_level", 12'h01C, gpio_level)
    `CHK("dac_load_strobe", 1'b0, dac_load_strobe)
    `CHK("dac_off_input_a", 1'b0, dac_off_input_a)
    `CHK("dac_off_input_b", 1'b0, dac_off_input_b)
    `CHK("dac_off_pd", 4'h0, dac_off_pd)
    `CHK("ext_ref_sel", 1'b1, ext_ref_sel)
    wr(dpf_pkg::SUB_DRIVER_EN, 16'h0000);
    settle();
    `CHK("pin_oe", 12'h000, pin_oe)
    $display("test gpio roles finished");
    test_done();
  end
endmodule
